// >>> hdl/rxmsr_defines.svh
// constants for the receiver modem status register block
//
// Contract
// - bit 13 reads the clear-to-send lead from the modem.
// - bit 12 reads the carrier-detect lead.
// - internal sync mode sets receiver-active after the configured sync count.
// - external sync or isochronous mode makes receiver-active follow sync-hunt.
// - receiver-active read-only, cleared by init, reset, sync-hunt falling.
// - bit 10 reads the secondary receive data lead.
// - bit 09 reads the data set ready lead.
// - with strip set, error-free sync characters set no ready flag.
// - strip, receive enable, sync-hunt are read/write, cleared by init/reset.
// - character-ready sets when synchronised and a character is loaded.
// - character-ready requests interrupt only while bit 06 is one.
// - character-ready read-only, cleared by init, reset, buffer read.
// - bit 05 enables interrupt on modem-status-change; cleared by init.
// - internal sync: sync-hunt enables sync character comparison.
// - isochronous: sync-hunt only enables character-ready generation.
// - external sync: sync-hunt enables ready flag and character framing.
// - bit 03 drives the secondary transmit data lead.
// - bit 02 drives request-to-send; software sets it before sending.
// - bit 01 drives the data-terminal-ready lead.
// - init clearing of the three modem output bits is selectable.
// - bit 15 sets on any modem lead change; cleared by init or read.
// - bit 00 reads zero; writes to read-only bits do nothing.
`ifndef RXMSR_DEFINES_SVH
`define RXMSR_DEFINES_SVH

// ==========================================================
// bit positions
`define RXMSR_BIT_CHANGE 15
`define RXMSR_BIT_RING 14
`define RXMSR_BIT_CTS 13
`define RXMSR_BIT_CARRIER 12
`define RXMSR_BIT_ACTIVE 11
`define RXMSR_BIT_SECRX 10
`define RXMSR_BIT_DSR 9
`define RXMSR_BIT_STRIP 8
`define RXMSR_BIT_DONE 7
`define RXMSR_BIT_RXIE 6
`define RXMSR_BIT_MCIE 5
`define RXMSR_BIT_HUNT 4
`define RXMSR_BIT_SECTX 3
`define RXMSR_BIT_RTS 2
`define RXMSR_BIT_DTR 1

// ==========================================================
// reset values
`define RXMSR_RESET_BIT 1'h0
`define RXMSR_REG_WIDTH 16

`endif

// >>> hdl/rxmsr_pkg.sv
// types for the receiver modem status register block
package rxmsr_pkg;

  typedef enum logic [1:0] {
    RXMSR_MODE_INTERNAL,
    RXMSR_MODE_EXTERNAL,
    RXMSR_MODE_ISO
  } rxmsr_mode_t;

  // modem input leads
  typedef struct packed {
    logic ring;
    logic clearToSend;
    logic carrier;
    logic secondaryReceive;
    logic modemReady;
  } rxmsr_leads_t;

  // receiver events presented to the register
  typedef struct packed {
    logic syncFound;
    logic charLoaded;
    logic charIsSync;
    logic charError;
  } rxmsr_rx_t;

endpackage

// >>> hdl/rxmsr_register.sv
// receiver control and status register with modem leads
`include "rxmsr_defines.svh"

module rxmsr_register
  import rxmsr_pkg::*;
#(
  parameter int SYNC_COUNT = 2,
  parameter bit CLEAR_MODEM_ON_INIT = 1'h1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic busInit,
  // register port
  input wire logic csrRead,
  input wire logic csrWrite,
  input wire logic [15:0] csrWriteData,
  output logic [15:0] csrReadData,
  input wire logic bufferRead,
  // receiver side
  input wire rxmsr_mode_t rxMode,
  input wire rxmsr_rx_t rxEvent,
  output logic huntEnable,
  output logic framingEnable,
  output logic doneEnable,
  // modem leads
  input wire rxmsr_leads_t leads,
  output logic secondaryTransmitOut,
  output logic requestToSendOut,
  output logic terminalReadyOut,
  // interrupt request
  output logic receiveIrq
);

  // ==========================================================
  // reset synchroniser
  logic rstMeta;
  logic rstSync_n;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'h0;
      rstSync_n <= 1'h0;
    end else begin
      rstMeta <= 1'h1;
      rstSync_n <= rstMeta;
    end
  end

  // ==========================================================
  // control bits
  logic syncStrip;
  logic receiveIrqEnable;
  logic modemChangeIrqEnable;
  logic syncHunt;
  logic secondaryTransmit;
  logic requestToSend;
  logic terminalReady;

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      syncStrip <= `RXMSR_RESET_BIT;
    end else if (busInit) begin
      syncStrip <= `RXMSR_RESET_BIT;
    end else if (csrWrite) begin
      syncStrip <= csrWriteData[`RXMSR_BIT_STRIP];
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      receiveIrqEnable <= `RXMSR_RESET_BIT;
    end else if (busInit) begin
      receiveIrqEnable <= `RXMSR_RESET_BIT;
    end else if (csrWrite) begin
      receiveIrqEnable <= csrWriteData[`RXMSR_BIT_RXIE];
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      modemChangeIrqEnable <= `RXMSR_RESET_BIT;
    end else if (busInit) begin
      modemChangeIrqEnable <= `RXMSR_RESET_BIT;
    end else if (csrWrite) begin
      modemChangeIrqEnable <= csrWriteData[`RXMSR_BIT_MCIE];
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      syncHunt <= `RXMSR_RESET_BIT;
    end else if (busInit) begin
      syncHunt <= `RXMSR_RESET_BIT;
    end else if (csrWrite) begin
      syncHunt <= csrWriteData[`RXMSR_BIT_HUNT];
    end
  end

  // optional clearing of modem outputs
  // master reset always clears; init only when the option is set
  // secondary transmit
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      secondaryTransmit <= `RXMSR_RESET_BIT;
    end else if (busInit && CLEAR_MODEM_ON_INIT) begin
      secondaryTransmit <= `RXMSR_RESET_BIT;
    end else if (csrWrite && !busInit) begin
      secondaryTransmit <= csrWriteData[`RXMSR_BIT_SECTX];
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      requestToSend <= `RXMSR_RESET_BIT;
    end else if (busInit && CLEAR_MODEM_ON_INIT) begin
      requestToSend <= `RXMSR_RESET_BIT;
    end else if (csrWrite && !busInit) begin
      requestToSend <= csrWriteData[`RXMSR_BIT_RTS];
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      terminalReady <= `RXMSR_RESET_BIT;
    end else if (busInit && CLEAR_MODEM_ON_INIT) begin
      terminalReady <= `RXMSR_RESET_BIT;
    end else if (csrWrite && !busInit) begin
      terminalReady <= csrWriteData[`RXMSR_BIT_DTR];
    end
  end

  // ==========================================================
  // modem lead sampling and change detect
  rxmsr_leads_t leadsPrev;
  logic leadsPrimed;
  localparam int LEAD_COUNT = $bits(rxmsr_leads_t);
  logic modemStatusChange;
  logic [LEAD_COUNT-1:0] leadToggle;

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      leadsPrev <= '0;
      leadsPrimed <= 1'h0;
    end else begin
      leadsPrev <= leads;
      leadsPrimed <= 1'h1;
    end
  end

  // first sample after reset is a capture, not a change
  for (genvar i = 0; i < LEAD_COUNT; i++) begin : g_leadToggle
    assign leadToggle[i] = leadsPrimed && (leads[i] != leadsPrev[i]);
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      modemStatusChange <= 1'h0;
    end else if (busInit) begin
      modemStatusChange <= 1'h0;
    end else if (|leadToggle) begin
      modemStatusChange <= 1'h1;
    end else if (csrRead) begin
      modemStatusChange <= 1'h0;
    end
  end

  // ==========================================================
  // receiver active
  logic receiverActive;
  logic huntPrev;
  logic [1:0] syncSeen;
  logic huntFall;

  assign huntFall = huntPrev && !syncHunt;

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      huntPrev <= 1'h0;
    end else begin
      huntPrev <= syncHunt;
    end
  end

  // count contiguous sync characters
  // a non-sync character breaks the run
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      syncSeen <= 2'h0;
    end else if (busInit || !syncHunt || rxMode != RXMSR_MODE_INTERNAL) begin
      syncSeen <= 2'h0;
    end else if (rxEvent.syncFound && syncSeen < 2'(SYNC_COUNT)) begin
      syncSeen <= syncSeen + 2'h1;
    end else if (rxEvent.charLoaded && !rxEvent.charIsSync &&
                 syncSeen < 2'(SYNC_COUNT)) begin
      syncSeen <= 2'h0;
    end
  end

  // cleared by init and hunt falling
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      receiverActive <= 1'h0;
    end else if (busInit || huntFall) begin
      receiverActive <= 1'h0;
    end else if (rxMode != RXMSR_MODE_INTERNAL) begin
      receiverActive <= syncHunt;
    end else if (syncHunt && rxEvent.syncFound &&
                 syncSeen + 2'h1 >= 2'(SYNC_COUNT)) begin
      receiverActive <= 1'h1;
    end
  end

  // ==========================================================
  // receiver enables
  // internal mode hunts for sync
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      huntEnable <= 1'h0;
    end else begin
      huntEnable <= syncHunt && rxMode == RXMSR_MODE_INTERNAL;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      framingEnable <= 1'h0;
    end else begin
      framingEnable <= syncHunt && rxMode == RXMSR_MODE_EXTERNAL;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      doneEnable <= 1'h0;
    end else begin
      doneEnable <= syncHunt && rxMode != RXMSR_MODE_INTERNAL;
    end
  end

  // ==========================================================
  // character ready
  logic charReady;
  logic stripThis;

  assign stripThis = syncStrip && rxEvent.charIsSync && !rxEvent.charError;

  // buffer read clears, a new character wins
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      charReady <= 1'h0;
    end else if (busInit) begin
      charReady <= 1'h0;
    end else if (rxEvent.charLoaded && receiverActive && syncHunt &&
                 !stripThis) begin
      charReady <= 1'h1;
    end else if (bufferRead) begin
      charReady <= 1'h0;
    end
  end

  // ==========================================================
  // interrupt request
  // gated OR of both flags
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      receiveIrq <= 1'h0;
    end else begin
      receiveIrq <= (charReady && receiveIrqEnable) ||
                    (modemStatusChange && modemChangeIrqEnable);
    end
  end

  // ==========================================================
  // modem lead outputs
  // secondary transmit pin
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      secondaryTransmitOut <= 1'h0;
    end else begin
      secondaryTransmitOut <= secondaryTransmit;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      requestToSendOut <= 1'h0;
    end else begin
      requestToSendOut <= requestToSend;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      terminalReadyOut <= 1'h0;
    end else begin
      terminalReadyOut <= terminalReady;
    end
  end

  // ==========================================================
  // read data
  logic [15:0] next_readData;

  always_comb begin
    next_readData = 16'h0000;
    next_readData[`RXMSR_BIT_CHANGE] = modemStatusChange;
    next_readData[`RXMSR_BIT_RING] = leads.ring;
    next_readData[`RXMSR_BIT_CTS] = leads.clearToSend;
    next_readData[`RXMSR_BIT_CARRIER] = leads.carrier;
    next_readData[`RXMSR_BIT_ACTIVE] = receiverActive;
    next_readData[`RXMSR_BIT_SECRX] = leads.secondaryReceive;
    next_readData[`RXMSR_BIT_DSR] = leads.modemReady;
    next_readData[`RXMSR_BIT_STRIP] = syncStrip;
    next_readData[`RXMSR_BIT_DONE] = charReady;
    next_readData[`RXMSR_BIT_RXIE] = receiveIrqEnable;
    next_readData[`RXMSR_BIT_MCIE] = modemChangeIrqEnable;
    next_readData[`RXMSR_BIT_HUNT] = syncHunt;
    next_readData[`RXMSR_BIT_SECTX] = secondaryTransmit;
    next_readData[`RXMSR_BIT_RTS] = requestToSend;
    next_readData[`RXMSR_BIT_DTR] = terminalReady;
  end

  // registered copy, updated every cycle
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      csrReadData <= 16'h0000;
    end else begin
      csrReadData <= next_readData;
    end
  end

endmodule

// >>> tb/rxmsr_modem.sv
// behavioural modem on the control and status leads
module rxmsr_modem
  import rxmsr_pkg::*;
(
  // clock and lead commands from the bench
  input wire logic mclk,
  input wire logic [4:0] cmd,
  // control leads from the interface
  input wire logic requestToSendOut,
  input wire logic terminalReadyOut,
  // status leads to the interface
  output rxmsr_leads_t leads
);
  timeunit 1ns;
  timeprecision 1ns;
  // ======
  // lead drive
  always @(posedge mclk) begin
    leads.ring <= cmd[4];
    leads.clearToSend <= cmd[3] & requestToSendOut;
    leads.carrier <= cmd[2];
    leads.secondaryReceive <= cmd[1];
    leads.modemReady <= cmd[0] & terminalReadyOut;
  end
endmodule

// >>> tb/rxmsr_register_checker.sv
// port assertions for the receiver modem status register
module rxmsr_register_checker
  import rxmsr_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic busInit,
  // register port
  input wire logic csrRead,
  input wire logic csrWrite,
  input wire logic [15:0] csrWriteData,
  input wire logic [15:0] csrReadData,
  input wire logic bufferRead,
  // receiver side
  input wire rxmsr_mode_t rxMode,
  input wire rxmsr_rx_t rxEvent,
  input wire logic huntEnable,
  input wire logic framingEnable,
  input wire logic doneEnable,
  // modem leads
  input wire rxmsr_leads_t leads,
  input wire logic secondaryTransmitOut,
  input wire logic requestToSendOut,
  input wire logic terminalReadyOut,
  input wire logic receiveIrq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ======
  // settle time after reset, lead and irq checks wait for it
  logic [2:0] upCnt;
  wire up = upCnt == 3'h7;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      upCnt <= 3'h0;
    end else if (!up) begin
      upCnt <= upCnt + 3'h1;
    end
  end
  property p_rts;
    csrWrite && csrWriteData[2] && !busInit ##1 !busInit[*2]
      |-> requestToSendOut;
  endproperty
  a_rts: assert property (p_rts) else $error("request lead low");
  property p_lead1;
    (up && $stable(leads))[*3]
      |-> csrReadData[13:12] == {leads.clearToSend, leads.carrier};
  endproperty
  a_lead1: assert property (p_lead1) else $error("lead bits");
  property p_lead2;
    (up && $stable(leads))[*3]
      |-> csrReadData[10:9] == {leads.secondaryReceive, leads.modemReady};
  endproperty
  a_lead2: assert property (p_lead2) else $error("lead bits");
  property p_chg;
    up && leads != $past(leads) && !busInit ##1 !busInit
      |-> ##1 csrReadData[15];
  endproperty
  a_chg: assert property (p_chg) else $error("change flag");
  property p_irq;
    up |-> receiveIrq == (csrReadData[7] && csrReadData[6]
      || csrReadData[15] && csrReadData[5]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_zero;
    csrReadData[0] == 1'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("bit 0 set");
  property p_init;
    busInit |-> ##2 (csrReadData & 16'h89f0) == 16'h0000;
  endproperty
  a_init: assert property (p_init) else $error("init");
  property p_ext;
    csrWrite && csrWriteData[4] && !busInit && rxMode == RXMSR_MODE_EXTERNAL
      ##1 (!busInit && !csrWrite && rxMode == RXMSR_MODE_EXTERNAL)[*2]
      |-> framingEnable && doneEnable && !huntEnable;
  endproperty
  a_ext: assert property (p_ext) else $error("ext enables");
endmodule

bind rxmsr_register rxmsr_register_checker rxmsr_register_checker_inst (
  .mclk(mclk), .rst_n(rst_n), .busInit(busInit), .csrRead(csrRead),
  .csrWrite(csrWrite), .csrWriteData(csrWriteData),
  .csrReadData(csrReadData), .bufferRead(bufferRead), .rxMode(rxMode),
  .rxEvent(rxEvent), .huntEnable(huntEnable),
  .framingEnable(framingEnable), .doneEnable(doneEnable), .leads(leads),
  .secondaryTransmitOut(secondaryTransmitOut),
  .requestToSendOut(requestToSendOut),
  .terminalReadyOut(terminalReadyOut), .receiveIrq(receiveIrq)
);

// >>> tb/rxmsr_register_tb.sv
// self-checking bench for the receiver modem status register
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin \
  failCount++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end

module rxmsr_register_tb;
  import rxmsr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst_n, busInit, csrRead, csrWrite, bufferRead;
  logic [15:0] csrWriteData, rd;
  rxmsr_mode_t rxMode;
  rxmsr_rx_t rxEvent;
  rxmsr_leads_t leads;
  logic [4:0] cmd;
  logic secTx, rts, dtr, irq, hunt, framing, done;
  int failCount, checks, cyc;
  // ======
  // design and modem
  rxmsr_register rxmsr_register_inst (.mclk(mclk), .rst_n(rst_n),
    .busInit(busInit), .csrRead(csrRead), .csrWrite(csrWrite),
    .csrWriteData(csrWriteData), .csrReadData(rd),
    .bufferRead(bufferRead), .rxMode(rxMode), .rxEvent(rxEvent),
    .huntEnable(hunt), .framingEnable(framing), .doneEnable(done),
    .leads(leads), .secondaryTransmitOut(secTx),
    .requestToSendOut(rts), .terminalReadyOut(dtr), .receiveIrq(irq));
  rxmsr_modem rxmsr_modem_inst (.mclk(mclk), .cmd(cmd),
    .requestToSendOut(rts), .terminalReadyOut(dtr), .leads(leads));
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  // ======
  // bus tasks
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(logic [15:0] d);
    @(posedge mclk) csrWrite <= 1'h1;
    csrWriteData <= d;
    @(posedge mclk) csrWrite <= 1'h0;
    tick(3);
  endtask
  task automatic ev(rxmsr_rx_t e);
    @(posedge mclk) rxEvent <= e;
    @(posedge mclk) rxEvent <= 4'h0;
    tick(3);
  endtask
  task automatic rdCsr;
    @(posedge mclk) csrRead <= 1'h1;
    @(posedge mclk) csrRead <= 1'h0;
    tick(3);
  endtask
  task automatic rdBuf;
    @(posedge mclk) bufferRead <= 1'h1;
    @(posedge mclk) bufferRead <= 1'h0;
    tick(3);
  endtask
  task automatic tRegs;
    `CHK("reset", 16'h0000, rd)
    wr(16'hffff);
    `CHK("rw bits", 16'h017e, rd)
    `CHK("lead outs", 3'h7, {secTx, rts, dtr})
    wr(16'h0000);
    `CHK("cleared", 3'h0, {secTx, rts, dtr})
  endtask
  task automatic tLeads;
    logic [15:0] pos [5];
    pos = '{16'h0200, 16'h0400, 16'h1000, 16'h2000, 16'h4000};
    wr(16'h0026);
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk) cmd <= 5'h01 << i;
      tick(4);
      `CHK("lead set", pos[i] | 16'h8026, rd)
      `CHK("chg irq", 1'h1, irq)
      rdCsr;
      `CHK("read clr", pos[i] | 16'h0026, rd)
      `CHK("irq off", 1'h0, irq)
    end
    @(posedge mclk) cmd <= 5'h00;
    wr(16'h0000);
    rdCsr;
    `CHK("leads idle", 16'h0000, rd)
  endtask
  task automatic tDone;
    wr(16'h0050);
    `CHK("hunt en", 1'h1, hunt)
    ev(4'h8);
    `CHK("one sync", 16'h0050, rd)
    ev(4'h8);
    `CHK("active", 16'h0850, rd)
    ev(4'h4);
    `CHK("done", 16'h08d0, rd)
    `CHK("rx irq", 1'h1, irq)
    rdBuf;
    `CHK("rx irq off", 1'h0, irq)
    `CHK("buf read", 16'h0850, rd)
    wr(16'h0150);
    ev(4'h6);
    `CHK("stripped", 16'h0950, rd)
    ev(4'h7);
    `CHK("err sync", 1'h1, rd[7])
    wr(16'h0000);
    `CHK("hunt fall", 1'h0, rd[11])
    rdBuf;
    `CHK("buf clr", 16'h0000, rd)
  endtask
  task automatic tExt;
    @(posedge mclk) rxMode <= RXMSR_MODE_EXTERNAL;
    wr(16'h0010);
    `CHK("ext active", 16'h0810, rd)
    `CHK("ext en", 3'h6, {framing, done, hunt})
    @(posedge mclk) rxMode <= RXMSR_MODE_ISO;
    tick(3);
    `CHK("iso en", 3'h2, {framing, done, hunt})
  endtask
  task automatic tInit;
    wr(16'h017e);
    @(posedge mclk) busInit <= 1'h1;
    @(posedge mclk) busInit <= 1'h0;
    tick(3);
    `CHK("init reg", 16'h0000, rd)
    `CHK("init outs", 3'h0, {secTx, rts, dtr})
  endtask
  task automatic printVerdict;
    $display("checks %0d failures %0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // hang guard, far above the roughly 170 cycles used
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      failCount++;
      printVerdict;
    end
  end
  initial begin
    {rst_n, busInit, csrRead, csrWrite, bufferRead} = 5'h00;
    csrWriteData = 16'h0000;
    rxMode = RXMSR_MODE_INTERNAL;
    rxEvent = 4'h0;
    cmd = 5'h00;
    repeat (20) @(posedge mclk);
    rst_n <= 1'h1;
    tick(3);
    tRegs;
    tLeads;
    tDone;
    tExt;
    tInit;
    printVerdict;
  end
endmodule
